/* uis_core.v */
// UART interrupt source priority encoder and line format control
//
// Contract
// RULE_01: Six priority levels; status read returns highest pending source code.
// RULE_02: Lower sources stay hidden while a higher one is pending.
// RULE_03: Line status is top priority with code 000110.
// RULE_04: Rx data available and rx timeout at priority two, codes 000100, 001100.
// RULE_05: Holding empty priority three 000010; modem status priority four 000000.
// RULE_06: Xoff or special char priority five 010000; flow change six 100000.
// RULE_07: Top two status bits read one when FIFOs enabled, else zero.
// RULE_08: Priority five and six bits active only with enhanced enable set.
// RULE_09: Xoff indication stays set until a matching Xon arrives.
// RULE_10: Lowest status bit zero when pending, one when idle and after reset.
// RULE_11: Top format bit opens divisor and enhanced register access; resets zero.
// RULE_12: Break bit forces serial output low until software clears it.
// RULE_13: Parity on bit three; bit four even; bit five forced parity.
// RULE_14: Stop bit control gives one, one and half for 5-bit, or two.
// RULE_15: Low two format bits select 5 to 8 data bits; default 5.
// RULE_16: Bits five and three set, four clear, force parity value one.
// RULE_17: FIFO enable bit must be one for other FIFO control bits to load.
`default_nettype none
`include "uis_defines.vh"

module uis_core (
	input  wire                   I_REF_CLK,
	input  wire                   I_SYS_RST,
	input  wire [`UIS_A_W-1:0]    I_ADDR,
	input  wire [7:0]             I_WDATA,
	input  wire                   I_WR,
	input  wire                   I_RD,
	output reg  [7:0]             O_RDATA,
	input  wire                   I_LINE_STATUS_SRC,
	input  wire                   I_RX_AVAILABLE_SRC,
	input  wire                   I_RX_TIMEOUT_SRC,
	input  wire                   I_TX_HOLDING_EMPTY_SRC,
	input  wire                   I_MODEM_STATUS_SRC,
	input  wire                   I_XOFF_DET,
	input  wire                   I_XON_DET,
	input  wire                   I_SPECIAL_CHAR_SRC,
	input  wire                   I_FLOW_CHANGE_SRC,
	input  wire                   I_TX_SERIAL,
	output reg                    O_SERIAL_TX_OUT,
	output wire                   O_INT,
	output wire                   O_DIV_LATCH_ACCESS,
	output wire [3:0]             O_DATA_BITS,
	output reg  [2:0]             O_STOP_HALVES,
	output wire                   O_PARITY_EN,
	output wire                   O_PARITY_EVEN,
	output wire                   O_PARITY_FORCED,
	output wire                   O_PARITY_FORCE_VAL,
	output wire                   O_FIFO_EN,
	output wire [4:0]             O_FIFO_CFG,
	output reg                    O_RX_FIFO_CLR,
	output reg                    O_TX_FIFO_CLR
);

	reg  [7:0]             line_fmt_r;
	reg  [7:0]             fifo_ctrl_r;
	reg  [7:0]             enh_feat_r;
	reg  [`UIS_EV_W-1:0]   int_stat_r;
	reg  [`UIS_EV_W-1:0]   int_stat_nxt;
	reg  [`UIS_EV_W-1:0]   int_mask_r;
	reg                    xoff_hold_r;
	reg  [5:0]             code;
	reg  [7:0]             rdata_nxt;
	wire [`UIS_EV_W-1:0]   events;
	wire [`UIS_EV_W-1:0]   pend;
	wire                   enh_en;
	wire                   wr_fmt;
	wire                   wr_fifo;
	wire                   wr_enh;
	wire                   wr_stat;
	wire                   wr_mask;
	wire                   fifo_on;
	wire                   any_pend;
	wire [7:0]             irq_source_reg;

	assign wr_fmt  = I_WR && (I_ADDR == `UIS_ADDR_LINE_FMT);
	assign wr_fifo = I_WR && (I_ADDR == `UIS_ADDR_FIFO_CTRL);
	// Enhanced register is hidden unless divisor access is open
	assign wr_enh  = I_WR && (I_ADDR == `UIS_ADDR_ENH_FEAT)
			&& line_fmt_r[`UIS_LF_DIV_ACC]; // RULE_11
	assign wr_stat = I_WR && (I_ADDR == `UIS_ADDR_INT_STAT);
	assign wr_mask = I_WR && (I_ADDR == `UIS_ADDR_INT_MASK);

	assign enh_en  = enh_feat_r[`UIS_EF_ENH_EN];
	assign fifo_on = fifo_ctrl_r[`UIS_FC_EN];

	assign events[`UIS_EV_LINE]  = I_LINE_STATUS_SRC;
	assign events[`UIS_EV_RXAV]  = I_RX_AVAILABLE_SRC;
	assign events[`UIS_EV_RXTO]  = I_RX_TIMEOUT_SRC;
	assign events[`UIS_EV_THRE]  = I_TX_HOLDING_EMPTY_SRC;
	assign events[`UIS_EV_MODEM] = I_MODEM_STATUS_SRC;
	assign events[`UIS_EV_XOFF]  = I_XOFF_DET | I_SPECIAL_CHAR_SRC;
	assign events[`UIS_EV_FLOW]  = I_FLOW_CHANGE_SRC;

	// Sticky status, write one to clear; a new event wins over the clear
	always @* begin
		int_stat_nxt = int_stat_r;
		if (wr_stat) begin
			int_stat_nxt = int_stat_r & ~I_WDATA[`UIS_EV_W-1:0];
		end
		int_stat_nxt = int_stat_nxt | events;
	end

	// Masked pending set; the two enhanced sources need the enable
	assign pend[`UIS_EV_W-3:0] = int_stat_r[`UIS_EV_W-3:0]
			& int_mask_r[`UIS_EV_W-3:0];
	assign pend[`UIS_EV_XOFF] = enh_en && int_mask_r[`UIS_EV_XOFF]
			&& (int_stat_r[`UIS_EV_XOFF] || xoff_hold_r); // RULE_08 RULE_09
	assign pend[`UIS_EV_FLOW] = enh_en && int_mask_r[`UIS_EV_FLOW]
			&& int_stat_r[`UIS_EV_FLOW]; // RULE_08

	assign any_pend = |pend;
	assign O_INT    = any_pend;

	// Fixed priority: the first match hides every lower source
	always @* begin
		if (pend[`UIS_EV_LINE]) begin
			code = `UIS_CODE_LINE; // RULE_03 RULE_01 RULE_02
		end else if (pend[`UIS_EV_RXTO]) begin
			code = `UIS_CODE_RXTO; // RULE_04
		end else if (pend[`UIS_EV_RXAV]) begin
			code = `UIS_CODE_RXAV; // RULE_04
		end else if (pend[`UIS_EV_THRE]) begin
			code = `UIS_CODE_THRE; // RULE_05
		end else if (pend[`UIS_EV_MODEM]) begin
			code = `UIS_CODE_MODEM; // RULE_05
		end else if (pend[`UIS_EV_XOFF]) begin
			code = `UIS_CODE_XOFF; // RULE_06
		end else if (pend[`UIS_EV_FLOW]) begin
			code = `UIS_CODE_FLOW; // RULE_06
		end else begin
			code = `UIS_CODE_NONE; // RULE_10
		end
	end

	assign irq_source_reg = {fifo_on, fifo_on, code}; // RULE_07

	// Line format decode
	assign O_DIV_LATCH_ACCESS = line_fmt_r[`UIS_LF_DIV_ACC]; // RULE_11
	assign O_DATA_BITS = `UIS_BITS_BASE
			+ {2'h0, line_fmt_r[`UIS_LF_LEN_HI:`UIS_LF_LEN_LO]}; // RULE_15
	assign O_PARITY_EN     = line_fmt_r[`UIS_LF_PAR_EN]; // RULE_13
	assign O_PARITY_FORCED = line_fmt_r[`UIS_LF_PAR_EN]
			&& line_fmt_r[`UIS_LF_PAR_FORCE]; // RULE_13
	assign O_PARITY_EVEN   = line_fmt_r[`UIS_LF_PAR_EVEN]; // RULE_13
	// Forced value is the inverse of the even bit
	assign O_PARITY_FORCE_VAL = ~line_fmt_r[`UIS_LF_PAR_EVEN]; // RULE_16

	always @* begin
		if (!line_fmt_r[`UIS_LF_STOP]) begin
			O_STOP_HALVES = `UIS_STOP_ONE; // RULE_14
		end else if (line_fmt_r[`UIS_LF_LEN_HI:`UIS_LF_LEN_LO]
				== `UIS_LEN_5) begin
			O_STOP_HALVES = `UIS_STOP_ONE_HALF; // RULE_14
		end else begin
			O_STOP_HALVES = `UIS_STOP_TWO; // RULE_14
		end
	end

	assign O_FIFO_EN  = fifo_on;
	assign O_FIFO_CFG = fifo_ctrl_r[7:3];

	// Read mux, unmapped addresses read zero
	always @* begin
		case (I_ADDR)
		`UIS_ADDR_IRQ_SRC:   rdata_nxt = irq_source_reg;
		`UIS_ADDR_LINE_FMT:  rdata_nxt = line_fmt_r;
		`UIS_ADDR_FIFO_CTRL: rdata_nxt = fifo_ctrl_r;
		`UIS_ADDR_ENH_FEAT: begin
			rdata_nxt = line_fmt_r[`UIS_LF_DIV_ACC] ?
					enh_feat_r : `UIS_RDATA_RST; // RULE_11
		end
		`UIS_ADDR_INT_STAT:  rdata_nxt = {1'b0, int_stat_r};
		`UIS_ADDR_INT_MASK:  rdata_nxt = {1'b0, int_mask_r};
		default:             rdata_nxt = `UIS_RDATA_RST;
		endcase
	end

	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			line_fmt_r      <= `UIS_LINE_FMT_RST;
			fifo_ctrl_r     <= `UIS_FIFO_CTRL_RST;
			enh_feat_r      <= `UIS_ENH_FEAT_RST;
			int_stat_r      <= `UIS_INT_STAT_RST;
			int_mask_r      <= `UIS_INT_MASK_RST;
			xoff_hold_r     <= 1'b0;
			O_RDATA         <= `UIS_RDATA_RST;
			O_SERIAL_TX_OUT <= `UIS_TX_IDLE;
			O_RX_FIFO_CLR   <= 1'b0;
			O_TX_FIFO_CLR   <= 1'b0;
		end else begin
			int_stat_r <= int_stat_nxt;
			// Data only in the cycle after the read strobe
			O_RDATA    <= I_RD ? rdata_nxt : `UIS_RDATA_RST;
			if (wr_fmt) begin
				line_fmt_r <= I_WDATA;
			end
			if (wr_enh) begin
				enh_feat_r <= I_WDATA;
			end
			if (wr_mask) begin
				int_mask_r <= I_WDATA[`UIS_EV_W-1:0];
			end
			// Xoff seen in the same cycle as Xon keeps the hold set
			if (I_XOFF_DET) begin
				xoff_hold_r <= 1'b1; // RULE_09
			end else if (I_XON_DET) begin
				xoff_hold_r <= 1'b0; // RULE_09
			end
			// Clear bits are self-clearing pulses and never stored
			O_RX_FIFO_CLR <= wr_fifo && I_WDATA[`UIS_FC_EN]
					&& I_WDATA[`UIS_FC_RX_CLR]; // RULE_17
			O_TX_FIFO_CLR <= wr_fifo && I_WDATA[`UIS_FC_EN]
					&& I_WDATA[`UIS_FC_TX_CLR]; // RULE_17
			if (wr_fifo) begin
				if (I_WDATA[`UIS_FC_EN]) begin
					fifo_ctrl_r <= I_WDATA & `UIS_FC_KEEP_MASK; // RULE_17
				end else begin
					fifo_ctrl_r <= `UIS_FIFO_CTRL_RST; // RULE_17
				end
			end
			// Break overrides the transmitter for as long as it is set
			O_SERIAL_TX_OUT <= line_fmt_r[`UIS_LF_BREAK] ?
					1'b0 : I_TX_SERIAL; // RULE_12
		end
	end

endmodule // uis_core

`default_nettype wire

/* uis_defines.vh */
// Constants for the UART interrupt status and line format block
`ifndef UIS_DEFINES_VH
`define UIS_DEFINES_VH

// Register indices on the local register port
`define UIS_A_W             3
`define UIS_ADDR_IRQ_SRC    3'h0
`define UIS_ADDR_LINE_FMT   3'h1
`define UIS_ADDR_FIFO_CTRL  3'h2
`define UIS_ADDR_ENH_FEAT   3'h3
`define UIS_ADDR_INT_STAT   3'h4
`define UIS_ADDR_INT_MASK   3'h5

// Reset values
`define UIS_LINE_FMT_RST    8'h00
`define UIS_FIFO_CTRL_RST   8'h00
`define UIS_ENH_FEAT_RST    8'h00
`define UIS_INT_STAT_RST    7'h00
`define UIS_INT_MASK_RST    7'h00
`define UIS_RDATA_RST       8'h00
`define UIS_TX_IDLE         1'b1

// Line format fields
`define UIS_LF_DIV_ACC      7
`define UIS_LF_BREAK        6
`define UIS_LF_PAR_FORCE    5
`define UIS_LF_PAR_EVEN     4
`define UIS_LF_PAR_EN       3
`define UIS_LF_STOP         2
`define UIS_LF_LEN_HI       1
`define UIS_LF_LEN_LO       0
`define UIS_LEN_5           2'h0
`define UIS_BITS_BASE       4'h5

// Stop length in half-bit units
`define UIS_STOP_ONE        3'h2
`define UIS_STOP_ONE_HALF   3'h3
`define UIS_STOP_TWO        3'h4

// FIFO control and enhanced feature fields
`define UIS_FC_EN           0
`define UIS_FC_RX_CLR       1
`define UIS_FC_TX_CLR       2
`define UIS_FC_KEEP_MASK    8'hF9
`define UIS_EF_ENH_EN       4

// Event bit positions in the sticky status and mask
`define UIS_EV_W            7
`define UIS_EV_LINE         0
`define UIS_EV_RXAV         1
`define UIS_EV_RXTO         2
`define UIS_EV_THRE         3
`define UIS_EV_MODEM        4
`define UIS_EV_XOFF         5
`define UIS_EV_FLOW         6

// Source codes in status bits five to zero
`define UIS_CODE_LINE       6'h06
`define UIS_CODE_RXAV       6'h04
`define UIS_CODE_RXTO       6'h0C
`define UIS_CODE_THRE       6'h02
`define UIS_CODE_MODEM      6'h00
`define UIS_CODE_XOFF       6'h10
`define UIS_CODE_FLOW       6'h20
`define UIS_CODE_NONE       6'h01

`endif

/* uis_props.sv */
// Checker for the UART interrupt status and line format block
`default_nettype none
`include "uis_defines.vh"
module uis_props (
	input wire logic                I_REF_CLK,
	input wire logic                I_SYS_RST,
	input wire logic [`UIS_A_W-1:0] I_ADDR,
	input wire logic                I_RD,
	input wire logic [7:0]          O_RDATA,
	input wire logic                I_TX_SERIAL,
	input wire logic                O_SERIAL_TX_OUT,
	input wire logic                O_INT,
	input wire logic [3:0]          O_DATA_BITS,
	input wire logic [2:0]          O_STOP_HALVES,
	input wire logic                O_PARITY_EN,
	input wire logic                O_PARITY_FORCED
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_src_read_code: assert property (I_RD && I_ADDR == 3'h0 |=> O_RDATA[5:0] inside
		{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
		else $error("status code outside table");
	a_pend_flag_int: assert property (I_RD && I_ADDR == 3'h0 |=> O_RDATA[0] == !$past(O_INT))
		else $error("idle flag disagrees with interrupt line");
	a_fifo_bits_pair: assert property (I_RD && I_ADDR == 3'h0 |=> O_RDATA[7] == O_RDATA[6])
		else $error("top status bits differ");
	a_rdata_one_cycle: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data outside its cycle");
	a_tx_low_follows: assert property (!I_TX_SERIAL |=> !O_SERIAL_TX_OUT)
		else $error("serial output high without data or break");
	a_len_range: assert property (O_DATA_BITS inside {4'h5, 4'h6, 4'h7, 4'h8})
		else $error("word length out of range");
	a_stop_half_len: assert property (O_STOP_HALVES == 3'h3 |-> O_DATA_BITS == 4'h5)
		else $error("one and a half stop bits on long word");
	a_force_needs_par: assert property (O_PARITY_FORCED |-> O_PARITY_EN)
		else $error("forced parity without parity enable");
	c_int_raised: cover property (O_INT);
	c_break_seen: cover property (I_TX_SERIAL ##1 !O_SERIAL_TX_OUT);
	c_pend_read: cover property (I_RD && I_ADDR == 3'h0 ##1 !O_RDATA[0]);
endmodule // uis_props
bind uis_core uis_props u_uis_props (.*);
`default_nettype wire

/* uis_peer.sv */
// Transmitter stand-in: a rotating bit pattern on the serial data input
`default_nettype none
module uis_peer (
	input  wire logic i_clk,
	output var  logic o_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pat_r = 4'h9;
	always @(posedge i_clk) pat_r <= {pat_r[2:0], pat_r[3]};
	assign o_bit = pat_r[3];
endmodule // uis_peer
`default_nettype wire

/* test_uis_core.sv */
// Self-checking bench for the UART interrupt status and line format block
`default_nettype none
`include "uis_defines.vh"
module test_uis_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_REF_CLK, I_SYS_RST, I_WR, I_RD, I_TX_SERIAL, O_SERIAL_TX_OUT, O_INT, O_FIFO_EN;
	logic O_DIV_LATCH_ACCESS, O_PARITY_EN, O_PARITY_EVEN, O_PARITY_FORCED, O_PARITY_FORCE_VAL;
	logic O_RX_FIFO_CLR, O_TX_FIFO_CLR, b;
	logic [`UIS_A_W-1:0] I_ADDR;
	logic [7:0] I_WDATA, O_RDATA;
	logic [3:0] O_DATA_BITS;
	logic [2:0] O_STOP_HALVES;
	logic [4:0] O_FIFO_CFG;
	logic [8:0] src;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	logic [5:0] code [7] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20};
	logic [7:0] clr [7] = '{8'h01, 8'h04, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
	uis_core u_uis_core (.*, .I_LINE_STATUS_SRC(src[0]), .I_RX_AVAILABLE_SRC(src[1]),
		.I_RX_TIMEOUT_SRC(src[2]), .I_TX_HOLDING_EMPTY_SRC(src[3]),
		.I_MODEM_STATUS_SRC(src[4]), .I_XOFF_DET(src[5]), .I_XON_DET(src[6]),
		.I_SPECIAL_CHAR_SRC(src[7]), .I_FLOW_CHANGE_SRC(src[8]));
	uis_peer u_uis_peer (.i_clk(I_REF_CLK), .o_bit(I_TX_SERIAL));
	task automatic results;
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge I_REF_CLK);
		I_ADDR <= a; I_WDATA <= d; I_WR <= 1'b1;
		@(posedge I_REF_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge I_REF_CLK);
		I_ADDR <= a; I_RD <= 1'b1;
		@(posedge I_REF_CLK);
		I_RD <= 1'b0;
		#1 chk(O_RDATA, e);
	endtask
	// Source bits: line, rxav, rxto, thre, modem, xoff, xon, special, flow
	task automatic ev(input logic [8:0] m);
		@(posedge I_REF_CLK);
		src <= m;
		@(posedge I_REF_CLK);
		src <= 9'h000;
	endtask
	task automatic t_reset;
		rd(3'h0, 8'h01);
		rd(3'h1, 8'h00);
		chk({4'h0, O_DATA_BITS}, 8'h05);
	endtask
	task automatic t_priority;
		wr(3'h5, 8'h7F); wr(3'h1, 8'h80); wr(3'h3, 8'h10);
		#1 chk({7'h0, O_DIV_LATCH_ACCESS}, 8'h01);
		rd(3'h3, 8'h10);
		wr(3'h1, 8'h00);
		rd(3'h3, 8'h00);
		ev(9'h19F);
		#1 chk({7'h0, O_INT}, 8'h01);
		for (int k = 0; k < 7; k++) begin
			rd(3'h0, {2'b00, code[k]});
			wr(3'h4, clr[k]);
		end
		rd(3'h0, 8'h01);
	endtask
	task automatic t_xoff;
		ev(9'h020); wr(3'h4, 8'h20);
		rd(3'h0, 8'h10);
		ev(9'h040);
		rd(3'h0, 8'h01);
		wr(3'h1, 8'h80); wr(3'h3, 8'h00); wr(3'h1, 8'h00); ev(9'h100);
		rd(3'h0, 8'h01);
		wr(3'h4, 8'h7F);
	endtask
	task automatic t_fifo_mask;
		wr(3'h2, 8'h01);
		rd(3'h0, 8'hC1);
		wr(3'h2, 8'hCF);
		#1 chk({O_FIFO_CFG, O_FIFO_EN, O_RX_FIFO_CLR, O_TX_FIFO_CLR}, 8'hCF);
		@(posedge I_REF_CLK);
		#1 chk({6'h0, O_RX_FIFO_CLR, O_TX_FIFO_CLR}, 8'h00);
		wr(3'h2, 8'hF8);
		rd(3'h2, 8'h00);
		rd(3'h0, 8'h01);
		wr(3'h5, 8'h00); ev(9'h001);
		#1 chk({7'h0, O_INT}, 8'h00);
		wr(3'h5, 8'h01);
		#1 chk({7'h0, O_INT}, 8'h01);
		rd(3'h0, 8'h06);
		wr(3'h4, 8'h01);
		#1 chk({7'h0, O_INT}, 8'h00);
		rd(3'h7, 8'h00);
	endtask
	task automatic t_format;
		for (int i = 0; i < 8; i++) begin
			wr(3'h1, i[7:0]);
			#1 chk({4'h0, O_DATA_BITS}, 8'(5 + i % 4));
			chk({5'h0, O_STOP_HALVES}, i < 4 ? 8'h02 : (i == 4 ? 8'h03 : 8'h04));
		end
		wr(3'h1, 8'h28);
		#1 chk({4'h0, O_PARITY_FORCED, O_PARITY_FORCE_VAL, O_PARITY_EN, O_PARITY_EVEN}, 8'h0E);
		wr(3'h1, 8'h38);
		#1 chk({4'h0, O_PARITY_FORCED, O_PARITY_FORCE_VAL, O_PARITY_EN, O_PARITY_EVEN}, 8'h0B);
		wr(3'h1, 8'h18);
		#1 chk({4'h0, O_PARITY_FORCED, O_PARITY_FORCE_VAL, O_PARITY_EN, O_PARITY_EVEN}, 8'h03);
	endtask
	task automatic t_break;
		wr(3'h1, 8'h40);
		repeat (5) begin
			@(posedge I_REF_CLK);
			#1 chk({7'h0, O_SERIAL_TX_OUT}, 8'h00);
		end
		wr(3'h1, 8'h00);
		#1;
		repeat (5) begin
			b = I_TX_SERIAL;
			@(posedge I_REF_CLK);
			#1 chk({7'h0, O_SERIAL_TX_OUT}, {7'h0, b});
		end
	endtask
	initial begin
		I_REF_CLK = 1'b0;
		forever #20 I_REF_CLK = ~I_REF_CLK;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge I_REF_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		I_SYS_RST = 1'b1; I_ADDR = 3'h0; I_WDATA = 8'h00; I_WR = 1'b0; I_RD = 1'b0; src = 9'h000;
		repeat (8) @(posedge I_REF_CLK);
		I_SYS_RST <= 1'b0;
		t_reset(); t_priority(); t_xoff(); t_fifo_mask(); t_format(); t_break();
		results();
	end
endmodule // test_uis_core
`default_nettype wire
